// ### rtl/fbsw_pkg.sv
// Constants for the fieldbus status word and alive-pulse supervision block
package fbsw_pkg;
    localparam int          FBSW_CLK_MHZ        = 250;
    localparam int          FBSW_WORD_W         = 16;
    // Control word fields
    localparam int          FBSW_CW_ON          = 0;
    localparam int          FBSW_CW_COAST_N     = 1;
    localparam int          FBSW_CW_QSTOP_N     = 2;
    localparam int          FBSW_CW_FAULT_ACK   = 7;
    localparam int          FBSW_CW_FB_EN       = 10;
    localparam int          FBSW_CW_ALIVE       = 11;
    // Status word fields
    localparam int          FBSW_SW_RDY_ON      = 0;
    localparam int          FBSW_SW_RDY_RUN     = 1;
    localparam int          FBSW_SW_RUNNING     = 2;
    localparam int          FBSW_SW_FAULT       = 3;
    localparam int          FBSW_SW_COAST_N     = 4;
    localparam int          FBSW_SW_QSTOP_N     = 5;
    localparam int          FBSW_SW_INHIBIT     = 6;
    localparam int          FBSW_SW_WARN        = 7;
    localparam int          FBSW_SW_AT_REF      = 8;
    localparam int          FBSW_SW_FB_CTRL     = 9;
    localparam int          FBSW_SW_ABOVE       = 10;
    localparam int          FBSW_SW_ECHO        = 15;
    // Alternative command word fields
    localparam int          FBSW_AW_START       = 0;
    localparam int          FBSW_AW_CCW         = 1;
    localparam int          FBSW_AW_RESET       = 2;
    // Alive timeout is set in milliseconds; one tick per ms
    localparam int          FBSW_MS_NS          = 1000000;
    localparam int          FBSW_CLK_NS         = 4;
    localparam int          FBSW_MS_CYCLES      = FBSW_MS_NS / FBSW_CLK_NS;
    localparam int          FBSW_MS_CNT_W       = 18;
    localparam int          FBSW_TMO_W          = 16;
    localparam logic [15:0] FBSW_WORD_RST       = 16'h0000;

    typedef enum logic [1:0] {
        FBSW_ST_IDLE  = 2'b00,
        FBSW_ST_WATCH = 2'b01,
        FBSW_ST_LOST  = 2'b11
    } fbsw_state_t;
endpackage : fbsw_pkg

// ### rtl/fbsw_ms_tick.sv
// Millisecond enable pulse divider
`timescale 1ns/1ps
module fbsw_ms_tick
    import fbsw_pkg::*;
#(
    parameter int MS_CYCLES = FBSW_MS_CYCLES
) (
    input  wire logic clk_i,
    input  wire logic resetn_i,
    input  wire logic restart_i,
    output logic      tick_o
);
    logic [FBSW_MS_CNT_W-1:0] cnt_r;
    localparam logic [FBSW_MS_CNT_W-1:0] LAST = FBSW_MS_CNT_W'(MS_CYCLES - 1);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_r <= '0;
        end else if (restart_i || cnt_r == LAST) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    assign tick_o = (cnt_r == LAST) && !restart_i;
endmodule : fbsw_ms_tick

// ### rtl/fbsw_status.sv
// Fieldbus status word assembly, alive-pulse supervision and command decode
//
// Contract
// [R01] Fault when control bit 11 stops toggling longer than the timeout.
// [R02] Timeout setting zero disables alive-pulse supervision entirely.
// [R03] Master toggles control bit 11 as a periodic square wave.
// [R04] Status bit 0: powered, initialised, pulses inhibited.
// [R05] Status bit 1: drive ready to run.
// [R06] Status bit 2: running, flux ready, brake open if feedback used.
// [R07] Status bit 3: drive in fault state.
// [R08] Status bit 4 low while coast stop commanded.
// [R09] Status bit 5 low while quick stop commanded.
// [R10] Status bit 6 set after fault, coast or quick stop.
// [R11] Bit 6 clears only after stops released, then switch-on asserted.
// [R12] Status bit 7 follows warning, no acknowledgement needed.
// [R13] Status bit 8: speed at reference within tolerance.
// [R14] Status bit 9: fieldbus control active and requested.
// [R15] Status bit 10: actual speed above limit setting.
// [R16] Status bit 15 echoes control bit 11.
// [R17] Alternative word: bit 0 start, bit 1 counter-clockwise.
// [R18] Alternative word: bit 2 rising edge resets faults; bits 3-15 ignored.
// [R19] Status bits 11 to 14 always zero.
`timescale 1ns/1ps
module fbsw_status
    import fbsw_pkg::*;
#(
    // Clock cycles per millisecond of the alive timeout
    parameter int MS_CYCLES = FBSW_MS_CYCLES
) (
    input  wire logic                   clk_i,
    input  wire logic                   resetn_i,
    // Primary control word from the fieldbus master
    input  wire logic [FBSW_WORD_W-1:0] control_word_i,
    input  wire logic                   control_valid_i,
    // Alternative command word
    input  wire logic [FBSW_WORD_W-1:0] simple_command_word_i,
    input  wire logic                   simple_command_valid_i,
    // Settings
    input  wire logic [FBSW_TMO_W-1:0]  alive_pulse_timeout_setting_i,
    input  wire logic [FBSW_WORD_W-1:0] speed_threshold_setting_a_i,
    // Drive condition inputs (asynchronous to this block)
    input  wire logic                   power_ok_i,
    input  wire logic                   init_done_i,
    input  wire logic                   pulses_inhibited_i,
    input  wire logic                   ready_run_i,
    input  wire logic                   modulating_i,
    input  wire logic                   flux_ready_i,
    input  wire logic                   brake_fb_used_i,
    input  wire logic                   brake_open_i,
    input  wire logic                   drive_fault_i,
    input  wire logic                   warning_i,
    input  wire logic                   remote_allowed_i,
    input  wire logic [FBSW_WORD_W-1:0] speed_actual_i,
    input  wire logic [FBSW_WORD_W-1:0] speed_ref_i,
    input  wire logic [FBSW_WORD_W-1:0] speed_tol_i,
    // Results
    output logic [FBSW_WORD_W-1:0]      drive_state_report_word_o,
    output logic                        link_lost_fault_o,
    output logic                        fault_active_o,
    output logic                        fault_reset_o,
    output logic                        start_cmd_o,
    output logic                        ccw_cmd_o
);
    // Two-stage synchronisers for the pin-side condition inputs
    localparam int NSYNC = 11;
    logic [NSYNC-1:0] cond_raw;
    logic [NSYNC-1:0] sync1_r;
    logic [NSYNC-1:0] sync2_r;

    assign cond_raw = {power_ok_i, init_done_i, pulses_inhibited_i, ready_run_i,
                       modulating_i, flux_ready_i, brake_fb_used_i, brake_open_i,
                       drive_fault_i, warning_i, remote_allowed_i};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                end else begin
                    sync1_r[gi] <= cond_raw[gi];
                    sync2_r[gi] <= sync1_r[gi];
                end
            end
        end
    endgenerate

    logic s_power, s_init, s_pinh, s_rdy, s_mod, s_flux;
    logic s_bfb, s_bopen, s_fault, s_warn, s_remote;
    assign {s_power, s_init, s_pinh, s_rdy, s_mod, s_flux,
            s_bfb, s_bopen, s_fault, s_warn, s_remote} = sync2_r;

    // Latched control word
    logic [FBSW_WORD_W-1:0] cw_r;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cw_r <= FBSW_WORD_RST;
        end else if (control_valid_i) begin
            cw_r <= control_word_i;
        end
    end

    logic cw_on, cw_coast_n, cw_qstop_n, cw_alive, cw_fb_en;
    assign cw_on      = cw_r[FBSW_CW_ON];
    assign cw_coast_n = cw_r[FBSW_CW_COAST_N];
    assign cw_qstop_n = cw_r[FBSW_CW_QSTOP_N];
    assign cw_alive   = cw_r[FBSW_CW_ALIVE];
    assign cw_fb_en   = cw_r[FBSW_CW_FB_EN];

    // Alternative command word decode
    logic aw_reset_prev_r;
    logic aw_reset_edge;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            start_cmd_o     <= 1'b0;
            ccw_cmd_o       <= 1'b0;
            aw_reset_prev_r <= 1'b0;
        end else if (simple_command_valid_i) begin
            start_cmd_o     <= simple_command_word_i[FBSW_AW_START]; // R17
            ccw_cmd_o       <= simple_command_word_i[FBSW_AW_CCW];   // R17
            aw_reset_prev_r <= simple_command_word_i[FBSW_AW_RESET];
        end
    end
    // Only bit 2's rising edge acts; upper bits are never looked at
    assign aw_reset_edge = simple_command_valid_i &&
                           simple_command_word_i[FBSW_AW_RESET] && !aw_reset_prev_r; // R18

    // Fault acknowledge from primary word bit 7 rising edge as well
    logic ack_prev_r;
    logic ack_edge;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack_prev_r <= 1'b0;
        end else begin
            ack_prev_r <= cw_r[FBSW_CW_FAULT_ACK];
        end
    end
    assign ack_edge = cw_r[FBSW_CW_FAULT_ACK] && !ack_prev_r;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fault_reset_o <= 1'b0;
        end else begin
            fault_reset_o <= aw_reset_edge || ack_edge; // R18
        end
    end

    // Alive-pulse supervision
    fbsw_state_t        state_r;
    logic [FBSW_TMO_W-1:0] quiet_ms_r;
    logic               alive_prev_r;
    logic               alive_toggle;
    logic               ms_tick;
    logic               sup_en;

    assign alive_toggle = cw_alive != alive_prev_r;
    assign sup_en       = alive_pulse_timeout_setting_i != '0; // R02

    fbsw_ms_tick #(
        .MS_CYCLES (MS_CYCLES)
    ) u_tick (
        .clk_i     (clk_i),
        .resetn_i  (resetn_i),
        .restart_i (alive_toggle),
        .tick_o    (ms_tick)
    );

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            alive_prev_r <= 1'b0;
        end else begin
            alive_prev_r <= cw_alive;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r    <= FBSW_ST_IDLE;
            quiet_ms_r <= '0;
        end else begin
            case (state_r)
                FBSW_ST_IDLE: begin
                    quiet_ms_r <= '0;
                    if (sup_en && alive_toggle) begin
                        state_r <= FBSW_ST_WATCH;
                    end
                end
                FBSW_ST_WATCH: begin
                    if (!sup_en) begin
                        state_r <= FBSW_ST_IDLE; // R02
                    end else if (alive_toggle) begin
                        quiet_ms_r <= '0;
                    end else if (ms_tick) begin
                        if (quiet_ms_r + 1'b1 >= alive_pulse_timeout_setting_i) begin
                            state_r <= FBSW_ST_LOST; // R01
                        end
                        quiet_ms_r <= quiet_ms_r + 1'b1;
                    end
                end
                FBSW_ST_LOST: begin
                    quiet_ms_r <= '0;
                    if (!sup_en) begin
                        state_r <= FBSW_ST_IDLE; // R02
                    end else if (fault_reset_o && alive_toggle) begin
                        state_r <= FBSW_ST_WATCH;
                    end
                end
                default: begin
                    state_r <= FBSW_ST_IDLE;
                end
            endcase
        end
    end

    assign link_lost_fault_o = (state_r == FBSW_ST_LOST); // R01
    assign fault_active_o    = s_fault || link_lost_fault_o; // R07

    // Switch-on inhibit latch
    logic inhibit_r;
    logic stops_clear_r;
    logic on_prev_r;
    logic inhibit_set;
    assign inhibit_set = fault_active_o || !cw_coast_n || !cw_qstop_n; // R10

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            inhibit_r     <= 1'b1;
            stops_clear_r <= 1'b0;
            on_prev_r     <= 1'b0;
        end else begin
            on_prev_r <= cw_on;
            if (inhibit_set) begin
                inhibit_r     <= 1'b1; // R10
                stops_clear_r <= 1'b0;
            end else if (!stops_clear_r) begin
                // Stops released; ON must be low first so its rise comes after
                stops_clear_r <= !cw_on; // R11
            end else if (cw_on && !on_prev_r) begin
                inhibit_r <= 1'b0; // R11
            end
        end
    end

    // Speed comparisons
    logic [FBSW_WORD_W-1:0] speed_err;
    assign speed_err = (speed_actual_i >= speed_ref_i) ? speed_actual_i - speed_ref_i
                                                       : speed_ref_i - speed_actual_i;

    // Registered status word
    logic [FBSW_WORD_W-1:0] status_nxt;
    always_comb begin
        status_nxt = FBSW_WORD_RST; // R19
        status_nxt[FBSW_SW_RDY_ON]  = s_power && s_init && s_pinh;           // R04
        status_nxt[FBSW_SW_RDY_RUN] = s_rdy;                                 // R05
        status_nxt[FBSW_SW_RUNNING] = s_mod && s_flux && (!s_bfb || s_bopen); // R06
        status_nxt[FBSW_SW_FAULT]   = fault_active_o;                        // R07
        status_nxt[FBSW_SW_COAST_N] = cw_coast_n;                            // R08
        status_nxt[FBSW_SW_QSTOP_N] = cw_qstop_n;                            // R09
        status_nxt[FBSW_SW_INHIBIT] = inhibit_r;                             // R10
        status_nxt[FBSW_SW_WARN]    = s_warn;                                // R12
        status_nxt[FBSW_SW_AT_REF]  = speed_err <= speed_tol_i;              // R13
        status_nxt[FBSW_SW_FB_CTRL] = s_remote && cw_fb_en;                  // R14
        status_nxt[FBSW_SW_ABOVE]   = speed_actual_i > speed_threshold_setting_a_i; // R15
        status_nxt[FBSW_SW_ECHO]    = cw_alive;                              // R16
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            drive_state_report_word_o <= FBSW_WORD_RST;
        end else begin
            drive_state_report_word_o <= status_nxt;
        end
    end

    // Assertions
    echo_follow_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ##1 drive_state_report_word_o[FBSW_SW_ECHO] == $past(cw_alive)) // R16
        else $error("Echo bit does not follow control bit 11");

    unused_zero_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        drive_state_report_word_o[14:11] == 4'h0) // R19
        else $error("Status bits 11 to 14 not zero");

    sup_off_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !sup_en |=> !link_lost_fault_o) // R02
        else $error("Alive fault raised with supervision disabled");

    lost_cause_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $rose(link_lost_fault_o) |-> $past(ms_tick) && !$past(alive_toggle)) // R01
        else $error("Alive fault raised without a silent millisecond");

    fault_bit_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        link_lost_fault_o |=> drive_state_report_word_o[FBSW_SW_FAULT]) // R07
        else $error("Fault bit low during alive fault");

    coast_bit_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !cw_coast_n |=> !drive_state_report_word_o[FBSW_SW_COAST_N]) // R08
        else $error("Coast stop bit not low");

    inhibit_set_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        inhibit_set |=> ##1 drive_state_report_word_o[FBSW_SW_INHIBIT]) // R10
        else $error("Inhibit not set after stop or fault");

    inhibit_clear_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $fell(inhibit_r) |-> $past(cw_on) && $past(stops_clear_r)) // R11
        else $error("Inhibit cleared without ordered switch-on");

    reset_edge_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        aw_reset_edge |=> fault_reset_o) // R18
        else $error("Fault reset pulse missing");

    quick_bit_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R09
        !cw_qstop_n |=> !drive_state_report_word_o[FBSW_SW_QSTOP_N])
        else $error("Quick stop bit not low");

    warn_follow_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R12
        ##1 drive_state_report_word_o[FBSW_SW_WARN] == $past(s_warn))
        else $error("Warning bit does not follow warning");

    above_limit_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R15
        speed_actual_i > speed_threshold_setting_a_i |=> drive_state_report_word_o[FBSW_SW_ABOVE])
        else $error("Above limit bit low");

    at_ref_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R13
        speed_actual_i == speed_ref_i |=> drive_state_report_word_o[FBSW_SW_AT_REF])
        else $error("At reference bit low at equal speed");

    fb_ctrl_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R14
        !cw_fb_en |=> !drive_state_report_word_o[FBSW_SW_FB_CTRL])
        else $error("Fieldbus control bit high while disabled");

    start_follow_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R17
        simple_command_valid_i && simple_command_word_i[FBSW_AW_START] |=> start_cmd_o)
        else $error("Start command not taken");

    ccw_follow_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R17
        simple_command_valid_i && !simple_command_word_i[FBSW_AW_CCW] |=> !ccw_cmd_o)
        else $error("Clockwise command not taken");

    lost_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R01
        link_lost_fault_o && sup_en && !fault_reset_o |=> link_lost_fault_o)
        else $error("Alive fault left without reset");

    running_bit_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R06
        !s_mod |=> !drive_state_report_word_o[FBSW_SW_RUNNING])
        else $error("Running bit high without modulation");
endmodule : fbsw_status

// ### sim/fbsw_master_model.sv
// Fieldbus master model: control word source with a square-wave alive pulse
`timescale 1ns/1ps
module fbsw_master_model
    import fbsw_pkg::*;
#(
    parameter int HALF_CYCLES = 8
) (
    input  wire logic                   clk_i,
    input  wire logic                   resetn_i,
    input  wire logic                   pulse_run_i,
    input  wire logic [FBSW_WORD_W-1:0] base_word_i,
    output logic [FBSW_WORD_W-1:0]      control_word_o,
    output logic                        control_valid_o
);
    int   half_cnt_r;
    logic alive_r;

    // Alive pulse toggles every half period while running, frozen otherwise
    always_ff @(negedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            half_cnt_r <= 0;
            alive_r    <= 1'b0;
        end else if (pulse_run_i) begin
            if (half_cnt_r == HALF_CYCLES - 1) begin
                half_cnt_r <= 0;
                alive_r    <= ~alive_r;
            end else begin
                half_cnt_r <= half_cnt_r + 1;
            end
        end
    end

    // Word changes off the sampling edge; qualifier held high as a level
    always_ff @(negedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            control_word_o  <= FBSW_WORD_RST;
            control_valid_o <= 1'b0;
        end else begin
            control_word_o  <= {base_word_i[15:12], alive_r, base_word_i[10:0]};
            control_valid_o <= 1'b1;
        end
    end
endmodule : fbsw_master_model

// ### sim/tb_fieldbus_status_and_watchdog.sv
// Self-checking bench for the fieldbus status word and alive-pulse block
`timescale 1ns/1ps
module tb_fieldbus_status_and_watchdog;
    import fbsw_pkg::*;
    // Short millisecond so the alive timeout is reachable in a short run
    localparam int MS_T = 50;
    logic        clk       = 1'b0;
    logic        resetn    = 1'b0;
    logic        pulse_run = 1'b0;
    logic        alt_valid = 1'b0;
    logic        inh       = 1'b1;
    logic        lost_exp  = 1'b0;
    logic [10:0] cond      = '0;
    logic [15:0] base      = '0;
    logic [15:0] alt       = '0;
    logic [15:0] tmo       = 16'h0001;
    logic [15:0] thr       = 16'hFFFF;
    logic [15:0] act       = '0;
    logic [15:0] sref      = '0;
    logic [15:0] tol       = '0;
    logic [15:0] cw;
    logic [15:0] sw;
    logic        cw_valid;
    logic        lost;
    logic        fact;
    logic        fres;
    logic        start;
    logic        ccw;
    int          err_count = 0;
    int          checks    = 0;

    always #2 clk = ~clk;

    fbsw_master_model #(.HALF_CYCLES(8)) i_master (
        .clk_i(clk), .resetn_i(resetn), .pulse_run_i(pulse_run), .base_word_i(base),
        .control_word_o(cw), .control_valid_o(cw_valid));

    fbsw_status #(.MS_CYCLES(MS_T)) i_dut (
        .clk_i(clk), .resetn_i(resetn), .control_word_i(cw), .control_valid_i(cw_valid),
        .simple_command_word_i(alt), .simple_command_valid_i(alt_valid),
        .alive_pulse_timeout_setting_i(tmo), .speed_threshold_setting_a_i(thr),
        .power_ok_i(cond[0]), .init_done_i(cond[1]), .pulses_inhibited_i(cond[2]),
        .ready_run_i(cond[3]), .modulating_i(cond[4]), .flux_ready_i(cond[5]),
        .brake_fb_used_i(cond[6]), .brake_open_i(cond[7]), .drive_fault_i(cond[8]),
        .warning_i(cond[9]), .remote_allowed_i(cond[10]), .speed_actual_i(act),
        .speed_ref_i(sref), .speed_tol_i(tol), .drive_state_report_word_o(sw),
        .link_lost_fault_o(lost), .fault_active_o(fact), .fault_reset_o(fres),
        .start_cmd_o(start), .ccw_cmd_o(ccw));

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    function automatic logic [15:0] exp_word();
        logic [15:0] w;
        logic [15:0] d;
        w = '0;
        d = (act > sref) ? act - sref : sref - act;
        w[FBSW_SW_RDY_ON]  = cond[0] & cond[1] & cond[2];
        w[FBSW_SW_RDY_RUN] = cond[3];
        w[FBSW_SW_RUNNING] = cond[4] & cond[5] & (~cond[6] | cond[7]);
        w[FBSW_SW_FAULT]   = cond[8] | lost_exp;
        w[FBSW_SW_COAST_N] = cw[FBSW_CW_COAST_N];
        w[FBSW_SW_QSTOP_N] = cw[FBSW_CW_QSTOP_N];
        w[FBSW_SW_INHIBIT] = inh;
        w[FBSW_SW_WARN]    = cond[9];
        w[FBSW_SW_AT_REF]  = (d <= tol);
        w[FBSW_SW_FB_CTRL] = cw[FBSW_CW_FB_EN] & cond[10];
        w[FBSW_SW_ABOVE]   = (act > thr);
        w[FBSW_SW_ECHO]    = cw[FBSW_CW_ALIVE];
        return w;
    endfunction : exp_word

    // Lets synchronisers and the status register catch up, then compares
    task automatic settle_chk(input string what);
        repeat (6) @(negedge clk);
        chk(sw, exp_word(), what);
        chk({15'h0000, fact}, {15'h0000, cond[8] | lost_exp}, "fault active");
    endtask : settle_chk

    task automatic test_conditions();
        logic [10:0] pats [3] = '{11'h7FF, 11'h77F, 11'h030};
        for (int i = 0; i < 14; i++) begin
            cond <= (i < 11) ? 11'(1 << i) : pats[i-11];
            settle_chk("condition bits");
        end
        cond <= '0;
        $display("test conditions done");
    endtask : test_conditions

    task automatic test_speed();
        logic [15:0] tv [5][4] = '{'{16'h0064, 16'h0064, 16'h0000, 16'h0063},
                                   '{16'h0069, 16'h0064, 16'h0005, 16'h0069},
                                   '{16'h005E, 16'h0064, 16'h0005, 16'h005D},
                                   '{16'h0064, 16'h006A, 16'h0005, 16'h00C8},
                                   '{16'hFFFF, 16'h0000, 16'hFFFE, 16'hFFFE}};
        for (int i = 0; i < 5; i++) begin
            act  <= tv[i][0];
            sref <= tv[i][1];
            tol  <= tv[i][2];
            thr  <= tv[i][3];
            settle_chk("speed bits");
        end
        $display("test speed done");
    endtask : test_speed

    task automatic test_inhibit();
        logic [15:0] wv [12] = '{16'h0006, 16'h0007, 16'h0005, 16'h0007, 16'h0006, 16'h0007,
                                 16'h0003, 16'h0006, 16'h0007, 16'h0007, 16'h0006, 16'h0407};
        logic [10:0] cv [12] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 11'h100, 0, 11'h400};
        logic        iv [12] = '{1, 0, 1, 1, 1, 0, 1, 1, 0, 1, 1, 0};
        for (int i = 0; i < 12; i++) begin
            base <= wv[i];
            cond <= cv[i];
            inh  <= iv[i];
            settle_chk("stop and inhibit bits");
        end
        $display("test inhibit done");
    endtask : test_inhibit

    task automatic test_alt();
        logic [15:0] av [7] = '{16'h0000, 16'h0001, 16'h0002, 16'h0004, 16'h0004, 16'hFFF8,
                                16'h0007};
        logic [2:0]  ev [7] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h0, 3'h0, 3'h7};
        logic [2:0]  n;
        for (int i = 0; i < 7; i++) begin
            alt       <= av[i];
            alt_valid <= 1'b1;
            @(negedge clk);
            alt_valid <= 1'b0;
            n = 3'h0;
            repeat (3) begin
                n = n + 3'(fres === 1'b1);
                @(negedge clk);
            end
            chk({13'h0000, n[0], ccw, start}, {13'h0000, ev[i]}, "alternative word");
        end
        base <= base | 16'h0080;
        n = 3'h0;
        repeat (8) begin
            @(negedge clk);
            n = n + 3'(fres === 1'b1);
        end
        chk({13'h0000, n}, 16'h0001, "primary fault reset pulse");
        base <= base & 16'hFF7F;
        $display("test alternative word done");
    endtask : test_alt

    task automatic test_alive();
        logic b;
        int   k;
        for (int r = 0; r < 2; r++) begin
            pulse_run <= 1'b1;
            b = cw[FBSW_CW_ALIVE];
            k = 0;
            while (cw[FBSW_CW_ALIVE] === b && k < 40) begin
                @(negedge clk);
                k++;
            end
            if (k == 40) begin
                err_count++;
                $display("mismatch at %0t: alive pulse never toggled", $time);
                tally_and_finish();
            end
            pulse_run <= 1'b0;
            settle_chk("alive echo");
        end
        pulse_run <= 1'b1;
        repeat (3000) @(negedge clk);
        chk({15'h0000, lost}, 16'h0000, "lost while pulse toggles");
        tmo       <= 16'h0002;
        pulse_run <= 1'b0;
        k = 0;
        while (lost !== 1'b1 && k < 4 * MS_T) begin
            @(negedge clk);
            k++;
        end
        if (k == 4 * MS_T) begin
            err_count++;
            $display("mismatch at %0t: alive fault never raised", $time);
            tally_and_finish();
        end
        chk({15'h0000, k >= 2 * MS_T - 12 && k <= 2 * MS_T + 4}, 16'h0001, "alive timeout");
        lost_exp = 1'b1;
        inh      <= 1'b1;
        settle_chk("alive fault word");
        tmo      <= 16'h0000;
        lost_exp = 1'b0;
        repeat (3000) @(negedge clk);
        chk({14'h0000, lost, fact}, 16'h0000, "lost with supervision off");
        $display("test alive pulse done");
    endtask : test_alive

    initial begin
        repeat (6) @(negedge clk);
        resetn <= 1'b1;
        test_conditions();
        test_speed();
        test_inhibit();
        test_alt();
        test_alive();
        tally_and_finish();
    end
endmodule : tb_fieldbus_status_and_watchdog
